// ==== inc/cyclic_sense_map.vh ====
// register map, field positions, reset values and timing counts of the periodic wake sensor
// assumes a 100 MHz fabric clock and a 1 us internal oscillator tick
`ifndef CYCLIC_SENSE_MAP_VH
`define CYCLIC_SENSE_MAP_VH

`define CS_CTRL_OFS 8'h00
`define CS_TIMER_OFS 8'h04
`define CS_STAT_OFS 8'h08

// control register fields
`define CTRL_MODE_LSB 0
`define CTRL_GPIO_LSB 2
`define CTRL_WKEN_BIT 5
`define CTRL_GPWK_BIT 6
`define CTRL_TMWK_BIT 7
`define CTRL_BUSWK_BIT 8
`define CTRL_RESET 9'h000

// timer register fields
`define TIMER_PER_LSB 0
`define TIMER_ON_LSB 4
`define TIMER_RESET 7'h00

// status register bits
`define STAT_WKWU_BIT 0
`define STAT_WKLVL_BIT 1
`define STAT_CMDF_BIT 2
`define STAT_TMWU_BIT 3
`define STAT_BUSWU_BIT 4
`define STAT_RST_BIT 5
`define STAT_GPWU_BIT 6

// operating modes
`define MODE_NORMAL 2'h0
`define MODE_STOP 2'h1
`define MODE_SLEEP 2'h2
`define MODE_RESTART 2'h3

// pin configuration code selecting the high-side periodic sense function
`define GPIO_HS_SENSE 3'h3

// on-time codes
`define ON_100US 3'h1
`define ON_300US 3'h2
`define ON_1MS 3'h3
`define ON_10MS 3'h4
`define ON_20MS 3'h5

// fabric clocks per 1 us oscillator tick, sized to the divider width
`define TICK_CYCLES 16'h0064

// times below are in oscillator ticks of 1 us
`define FILTER_US 5'h10
`define INT_PULSE_US 7'h64
`define ONT_100US 30'h00000064
`define ONT_300US 30'h0000012C
`define ONT_1MS 30'h000003E8
`define ONT_10MS 30'h00002710
`define ONT_20MS 30'h00004E20

`define PER_10MS 30'h00002710
`define PER_20MS 30'h00004E20
`define PER_50MS 30'h0000C350
`define PER_100MS 30'h000186A0
`define PER_200MS 30'h00030D40
`define PER_500MS 30'h0007A120
`define PER_1S 30'h000F4240
`define PER_2S 30'h001E8480
`define PER_5S 30'h004C4B40
`define PER_10S 30'h00989680
`define PER_20S 30'h01312D00
`define PER_50S 30'h02FAF080
`define PER_100S 30'h05F5E100
`define PER_200S 30'h0BEBC200
`define PER_500S 30'h1DCD6500
`define PER_1000S 30'h3B9ACA00

`endif

// ==== core/osc_tick.v ====
// divider that stands in for the internal oscillator: one-cycle tick every div cycles
// assumes div is at least 2
`timescale 1ns/1ns
`default_nettype none
module osc_tick #(
    parameter [15:0] DIV = 16'h0064
) (
    input wire aclk,
    input wire aresetn,
    output reg tick
);
    reg [15:0] cnt_q;

    always @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= 16'h0000;
            tick <= 1'b0;
        end else begin
            tick <= (cnt_q == DIV - 16'h0001);
            if (cnt_q == DIV - 16'h0001) begin
                cnt_q <= 16'h0000;
            end else begin
                cnt_q <= cnt_q + 16'h0001;
            end
        end
    end
endmodule // osc_tick
`default_nettype wire

// ==== core/sense_filter.v ====
// stability filter started at the end of an on-time
// assumes din is synchronous to aclk; counts oscillator ticks
`timescale 1ns/1ns
`default_nettype none
`include "cyclic_sense_map.vh"
module sense_filter (
    input wire aclk,
    input wire aresetn,
    input wire tick,
    input wire start,
    input wire din,
    output reg done,
    output reg stable,
    output reg level
);
    reg busy_q;
    reg [4:0] cnt_q;

    always @(posedge aclk) begin
        if (!aresetn) begin
            busy_q <= 1'b0;
            cnt_q <= 5'h00;
            done <= 1'b0;
            stable <= 1'b0;
            level <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                busy_q <= 1'b1;
                cnt_q <= 5'h00;
                stable <= 1'b1;
                level <= din;
            end else if (busy_q) begin
                if (din != level) begin
                    stable <= 1'b0;
                end
                if (tick) begin
                    if (cnt_q == `FILTER_US - 5'h01) begin
                        busy_q <= 1'b0;
                        done <= 1'b1;
                    end else begin
                        cnt_q <= cnt_q + 5'h01;
                    end
                end
            end
        end
    end
endmodule // sense_filter
`default_nettype wire

// ==== core/cyclic_sense_wake_detect.v ====
// periodic wake-input sensing with wake source selection and mode handling
// assumes an AXI4-Lite master, synchronous inputs and bus wake inputs given as pulses
//
// Summary of operation
// - in sense configuration the high-side output turns on each period for on-time.
// - a sensed change wakes: interrupt low in Normal/Stop, supply on after Sleep.
// - timer starts when a valid on-time is written, independent of pin and filter.
// - low-power request without any valid wake source enters Restart at once.
// - command failure flag set when on-time exceeds period.
// - writing the on-time in sense configuration starts a new learning cycle.
// - first sample is only reference; later differing sample triggers wake.
// - filter starts at end of on-time; wake only if level stayed stable.
// - a periodic sense wake sets the wake-input event flag.
// - during periodic sensing the level status takes only on-time samples.
// - in Stop mode event flag and level bit update only with shortest on-time.
// - a wake is raised even when the event flag is already set.
// - static sensing wakes continuously from enabled wake inputs.
// - timer wake comes from the timer alone, no input pin used.
// - bus wake accepted on wake pattern or wake frame.
// - period field selects one of sixteen periods, 10 ms to 1000 s.
// - Sleep wake goes through Restart to Normal; Stop wake raises interrupt.
`timescale 1ns/1ns
`default_nettype none
`include "cyclic_sense_map.vh"
module cyclic_sense_wake_detect #(
    parameter [15:0] TICK_DIV = `TICK_CYCLES
) (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire wake_sense_input,
    input wire gpio_wake_input,
    input wire bus_wake_pattern,
    input wire bus_wake_frame,
    output reg high_side_output,
    output reg interrupt_out_n,
    output reg main_supply_rail
);
    localparam [1:0] RESP_OKAY = 2'h0;
    localparam [1:0] RESP_SLVERR = 2'h2;

    function [29:0] per_len;
        input [3:0] code;
        begin
            case (code)
                4'h0: per_len = `PER_10MS;
                4'h1: per_len = `PER_20MS;
                4'h2: per_len = `PER_50MS;
                4'h3: per_len = `PER_100MS;
                4'h4: per_len = `PER_200MS;
                4'h5: per_len = `PER_500MS;
                4'h6: per_len = `PER_1S;
                4'h7: per_len = `PER_2S;
                4'h8: per_len = `PER_5S;
                4'h9: per_len = `PER_10S;
                4'hA: per_len = `PER_20S;
                4'hB: per_len = `PER_50S;
                4'hC: per_len = `PER_100S;
                4'hD: per_len = `PER_200S;
                4'hE: per_len = `PER_500S;
                default: per_len = `PER_1000S;
            endcase
        end
    endfunction

    // zero marks an on-time code that leaves the timer stopped
    function [29:0] on_len;
        input [2:0] code;
        begin
            case (code)
                `ON_100US: on_len = `ONT_100US;
                `ON_300US: on_len = `ONT_300US;
                `ON_1MS: on_len = `ONT_1MS;
                `ON_10MS: on_len = `ONT_10MS;
                `ON_20MS: on_len = `ONT_20MS;
                default: on_len = 30'h00000000;
            endcase
        end
    endfunction

    reg [7:0] awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    reg aw_have_q;
    reg w_have_q;
    reg [8:0] ctrl_q;
    reg [6:0] timer_q;
    reg [1:0] mode_q;
    reg wake_input_event_flag_q, wake_level_bit_q, cmdf_q, tm_wu_q, bus_wu_q, rst_q, gp_wu_q;
    reg run_q;
    reg first_q;
    reg ref_valid_q;
    reg ref_q;
    reg [29:0] pcnt_q;
    reg [6:0] int_cnt_q;
    reg sense_prev_q;
    reg gpio_prev_q;

    wire tick;
    wire flt_done;
    wire flt_stable;
    wire flt_level;

    wire cs_cfg = (ctrl_q[`CTRL_GPIO_LSB +: 3] == `GPIO_HS_SENSE);
    wire wake_input_enable = ctrl_q[`CTRL_WKEN_BIT];
    wire gp_en = ctrl_q[`CTRL_GPWK_BIT];
    wire tm_en = ctrl_q[`CTRL_TMWK_BIT];
    wire bus_en = ctrl_q[`CTRL_BUSWK_BIT];
    wire [29:0] cur_on = on_len(timer_q[`TIMER_ON_LSB +: 3]);
    wire [29:0] cur_per = per_len(timer_q[`TIMER_PER_LSB +: 4]);
    wire cs_active = cs_cfg & run_q;
    wire hs_on = run_q & (pcnt_q < cur_on);
    // with an over-long on-time the filter starts at the period wrap while the output stays on
    wire on_end = tick & hs_on & ((pcnt_q == cur_on - 30'h1) | (pcnt_q == cur_per - 30'h1));
    wire cyc_start = tick & run_q & (pcnt_q == 30'h0);
    wire stop_gate = (mode_q != `MODE_STOP) | (timer_q[`TIMER_ON_LSB +: 3] == `ON_100US);
    wire cs_wake = flt_done & flt_stable & cs_cfg & ref_valid_q & (flt_level != ref_q);
    wire cs_sample = flt_done & flt_stable & cs_cfg;
    wire st_wake = wake_input_enable & ~cs_active & (wake_sense_input != sense_prev_q);
    wire gp_wake = gp_en & (gpio_wake_input != gpio_prev_q);
    wire tm_wake = cyc_start & ~first_q & tm_en;
    wire bus_wake = bus_en & (bus_wake_pattern | bus_wake_frame);
    wire any_wake = cs_wake | st_wake | gp_wake | tm_wake | bus_wake;
    wire src_valid = wake_input_enable | gp_en | bus_en | (run_q & (cs_cfg | tm_en));
    wire flags_set = wake_input_event_flag_q | tm_wu_q | bus_wu_q | gp_wu_q;

    wire wr_go = aw_have_q & w_have_q & ~s_axi_bvalid;
    wire wr_ctrl = wr_go & (awaddr_q == `CS_CTRL_OFS);
    wire wr_timer = wr_go & (awaddr_q == `CS_TIMER_OFS) & wstrb_q[0];
    wire wr_stat = wr_go & (awaddr_q == `CS_STAT_OFS) & wstrb_q[0];
    wire [6:0] new_timer = wdata_q[6:0];
    wire [29:0] new_on = on_len(new_timer[`TIMER_ON_LSB +: 3]);
    wire [7:0] w1c = wr_stat ? wdata_q[7:0] : 8'h00;

    osc_tick #(
        .DIV(TICK_DIV)
    ) u_tick (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick)
    );

    sense_filter u_filter (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick),
        .start(on_end),
        .din(wake_sense_input),
        .done(flt_done),
        .stable(flt_stable),
        .level(flt_level)
    );

    // bus slave: address and data are taken in either order, answered once both are held
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
        end else begin
            s_axi_awready <= ~aw_have_q & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready <= ~w_have_q & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid & s_axi_awready) begin
                aw_have_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_have_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (awaddr_q == `CS_CTRL_OFS || awaddr_q == `CS_TIMER_OFS ||
                    awaddr_q == `CS_STAT_OFS) begin
                    s_axi_bresp <= RESP_OKAY;
                end else begin
                    s_axi_bresp <= RESP_SLVERR;
                end
            end else if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & s_axi_arvalid;
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= RESP_OKAY;
                case (s_axi_araddr)
                    `CS_CTRL_OFS: s_axi_rdata <= {23'h000000, ctrl_q[8:2], mode_q};
                    `CS_TIMER_OFS: s_axi_rdata <= {25'h0000000, timer_q};
                    `CS_STAT_OFS: s_axi_rdata <= {25'h0000000, gp_wu_q, rst_q, bus_wu_q,
                                                  tm_wu_q, cmdf_q, wake_level_bit_q, wake_input_event_flag_q};
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // configuration and operating mode
    always @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= `CTRL_RESET;
            timer_q <= `TIMER_RESET;
            mode_q <= `MODE_NORMAL;
        end else begin
            if (wr_ctrl) begin
                if (wstrb_q[0]) begin
                    ctrl_q[7:0] <= wdata_q[7:0];
                end
                if (wstrb_q[1]) begin
                    ctrl_q[8] <= wdata_q[8];
                end
            end
            if (wr_timer) begin
                timer_q <= new_timer;
            end
            case (mode_q)
                `MODE_RESTART: mode_q <= `MODE_NORMAL;
                `MODE_SLEEP: begin
                    if (any_wake) begin
                        mode_q <= `MODE_RESTART;
                    end
                end
                default: begin
                    if (wr_ctrl & wstrb_q[0] & (wdata_q[1:0] != `MODE_NORMAL)) begin
                        // pending flags would lose a wake across the sleep transition
                        if (!src_valid || (wdata_q[1:0] == `MODE_SLEEP && flags_set)) begin
                            mode_q <= `MODE_RESTART;
                        end else begin
                            mode_q <= wdata_q[1:0];
                        end
                    end else if (wr_ctrl & wstrb_q[0]) begin
                        mode_q <= wdata_q[1:0];
                    end
                end
            endcase
        end
    end

    // sensing timer, learning cycle and reference
    always @(posedge aclk) begin
        if (!aresetn) begin
            run_q <= 1'b0;
            first_q <= 1'b1;
            ref_valid_q <= 1'b0;
            ref_q <= 1'b0;
            pcnt_q <= 30'h0;
        end else begin
            if (wr_timer) begin
                run_q <= (new_on != 30'h0);
                pcnt_q <= 30'h0;
                first_q <= 1'b1;
                ref_valid_q <= 1'b0;
            end else begin
                if (tick & run_q) begin
                    if (pcnt_q >= cur_per - 30'h1) begin
                        pcnt_q <= 30'h0;
                    end else begin
                        pcnt_q <= pcnt_q + 30'h1;
                    end
                end
                if (cyc_start) begin
                    first_q <= 1'b0;
                end
                if (cs_sample) begin
                    ref_q <= flt_level;
                    ref_valid_q <= 1'b1;
                end
            end
        end
    end

    // status flags: a hardware set wins over a software clear in the same cycle
    always @(posedge aclk) begin
        if (!aresetn) begin
            wake_input_event_flag_q <= 1'b0;
            wake_level_bit_q <= 1'b0;
            cmdf_q <= 1'b0;
            tm_wu_q <= 1'b0;
            bus_wu_q <= 1'b0;
            rst_q <= 1'b0;
            gp_wu_q <= 1'b0;
            sense_prev_q <= 1'b0;
            gpio_prev_q <= 1'b0;
        end else begin
            sense_prev_q <= wake_sense_input;
            gpio_prev_q <= gpio_wake_input;
            wake_input_event_flag_q <= ((cs_wake & stop_gate) | st_wake) | (wake_input_event_flag_q & ~w1c[`STAT_WKWU_BIT]);
            if (cs_active) begin
                if (cs_sample & stop_gate) begin
                    wake_level_bit_q <= flt_level;
                end
            end else begin
                wake_level_bit_q <= wake_sense_input;
            end
            cmdf_q <= (wr_timer & (new_on > per_len(new_timer[3:0]))) |
                      (cmdf_q & ~w1c[`STAT_CMDF_BIT]);
            tm_wu_q <= tm_wake | (tm_wu_q & ~w1c[`STAT_TMWU_BIT]);
            bus_wu_q <= bus_wake | (bus_wu_q & ~w1c[`STAT_BUSWU_BIT]);
            gp_wu_q <= gp_wake | (gp_wu_q & ~w1c[`STAT_GPWU_BIT]);
            rst_q <= (mode_q == `MODE_RESTART) | (rst_q & ~w1c[`STAT_RST_BIT]);
        end
    end

    // pins; a wake in Normal or Stop retriggers the interrupt pulse whatever the flags hold
    always @(posedge aclk) begin
        if (!aresetn) begin
            int_cnt_q <= 7'h00;
            interrupt_out_n <= 1'b1;
            high_side_output <= 1'b0;
            main_supply_rail <= 1'b1;
        end else begin
            if (any_wake & (mode_q == `MODE_NORMAL || mode_q == `MODE_STOP)) begin
                int_cnt_q <= `INT_PULSE_US;
                interrupt_out_n <= 1'b0;
            end else if (int_cnt_q != 7'h00) begin
                if (tick) begin
                    int_cnt_q <= int_cnt_q - 7'h01;
                    interrupt_out_n <= (int_cnt_q == 7'h01);
                end
            end else begin
                interrupt_out_n <= 1'b1;
            end
            high_side_output <= hs_on & cs_cfg;
            main_supply_rail <= (mode_q != `MODE_SLEEP) | any_wake;
        end
    end
endmodule // cyclic_sense_wake_detect
`default_nettype wire

// ==== dv/cyclic_sense_wake_detect_properties.sv ====
// concurrent checks on the ports of the periodic wake sensor
// assumes one clock domain and binding to the design top by port name
`timescale 1ns/1ns
`default_nettype none
module cyclic_sense_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic high_side_output,
    input wire logic interrupt_out_n,
    input wire logic main_supply_rail
);
    logic timer_seen_q;
    // shadow of the timer write, so the switch can be tied to its cause
    always @(posedge aclk) begin
        if (!aresetn) begin
            timer_seen_q <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready && s_axi_awaddr == 8'h04) begin
            timer_seen_q <= 1'b1;
        end
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_hs_needs_timer: assert property (high_side_output |-> timer_seen_q)
        else $error("high-side switch on before any timer write");
    a_hs_on_min: assert property ($rose(high_side_output) |-> high_side_output[*8])
        else $error("high-side on-time too short");
    a_int_low_min: assert property ($fell(interrupt_out_n) |-> !interrupt_out_n[*8])
        else $error("interrupt pulse too short");
    a_filter_quiet: assert property (
        $fell(high_side_output) && interrupt_out_n |-> interrupt_out_n[*8])
        else $error("wake raised inside the filter interval");
    a_rail_stays_up: assert property ($rose(main_supply_rail) |=> main_supply_rail[*8])
        else $error("supply dropped right after wake");
    a_write_resp_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response not released");
    a_read_resp_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read response not released");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
endmodule // cyclic_sense_checker
bind cyclic_sense_wake_detect cyclic_sense_checker chk_i (.*);
`default_nettype wire

// ==== dv/sense_network.sv ====
// switch network on the wake input, powered from the high-side output
// assumes a pull-down on the sense line; line capacitance holds a level briefly
`timescale 1ns/1ns
`default_nettype none
module sense_network #(
    parameter int HOLD_NS = 800
) (
    input wire logic high_side_output,
    input wire logic switch_closed,
    output var logic wake_sense_input
);
    initial wake_sense_input = 1'b0;
    always @(high_side_output or switch_closed) begin
        if (high_side_output) begin
            wake_sense_input = switch_closed;
        end
    end
    // unpowered network: the pull-down wins once the held charge is gone
    always @(negedge high_side_output) begin
        #(HOLD_NS);
        if (!high_side_output) begin
            wake_sense_input = 1'b0;
        end
    end
endmodule // sense_network
`default_nettype wire

// ==== dv/cyclic_sense_wake_detect_tb.sv ====
// self-checking bench of the periodic wake sensor
// assumes the design top, its map header, the checker bind and the switch model
`timescale 1ns/1ns
`default_nettype none
module cyclic_sense_wake_detect_tb;
    localparam int DIV = 2;
    logic aclk, aresetn, sw, bad;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic [31:0] s_axi_wdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] r;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic gpio_wake_input, bus_wake_pattern, bus_wake_frame;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire wake_sense_input, high_side_output, interrupt_out_n, main_supply_rail;
    int n_mismatch, checks, i, n, k;

    cyclic_sense_wake_detect #(.TICK_DIV(16'h0002)) dut (.*);
    sense_network #(.HOLD_NS(40 * DIV * 10)) net (
        .high_side_output(high_side_output),
        .switch_closed(sw),
        .wake_sense_input(wake_sense_input)
    );

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic limit(input int j, input int m);
        if (j >= m) begin
            n_mismatch++;
            $display("MISMATCH t=%0t wait ran out %h %h", $time, j, m);
            print_verdict();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        limit(i, 50);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        limit(i, 50);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        chk(d, exp);
    endtask
    // which: 1 watches the high-side switch, 0 the interrupt line
    task automatic wait_on(input bit which, input logic lvl, input int m);
        for (n = 0; n < m; n++) begin
            if ((which ? high_side_output : interrupt_out_n) === lvl) break;
            @(posedge aclk);
        end
        limit(n, m);
    endtask

    task automatic t_regs;
        chk({main_supply_rail, interrupt_out_n, high_side_output}, 32'h6);
        rchk(8'h00, 32'h0);
        rchk(8'h04, 32'h0);
        rchk(8'h08, 32'h0);
        wr(8'h0C, 32'hFF);
        chk(r, 32'h2);
        rd(8'h0C);
        chk({d[29:0], r}, 32'h2);
        $display("test regs done");
    endtask
    task automatic t_fail;
        wr(8'h04, 32'h40);
        rchk(8'h08, 32'h0);
        wr(8'h04, 32'h50);
        rchk(8'h08, 32'h4);
        wr(8'h04, 32'h0);
        wr(8'h08, 32'h4);
        rchk(8'h08, 32'h0);
        $display("test command failure done");
    endtask
    task automatic t_sleep;
        wr(8'h00, 32'h2);
        repeat (5) @(posedge aclk);
        chk(main_supply_rail, 32'h1);
        rchk(8'h00, 32'h0);
        rchk(8'h08, 32'h20);
        wr(8'h08, 32'h20);
        wr(8'h00, 32'h1);
        rchk(8'h08, 32'h20);
        wr(8'h08, 32'h20);
        $display("test sleep refusal done");
    endtask
    task automatic t_bus;
        wr(8'h00, 32'h40);
        gpio_wake_input <= 1'b1;
        wait_on(0, 1'b0, 20);
        rchk(8'h08, 32'h40);
        wr(8'h08, 32'h40);
        wait_on(0, 1'b1, 300);
        wr(8'h00, 32'h100);
        for (k = 0; k < 2; k++) begin
            bus_wake_pattern <= (k == 0);
            bus_wake_frame <= (k == 1);
            @(posedge aclk);
            bus_wake_pattern <= 1'b0;
            bus_wake_frame <= 1'b0;
            wait_on(0, 1'b0, 20);
            rchk(8'h08, 32'h10);
            wr(8'h08, 32'h10);
            wait_on(0, 1'b1, 300);
        end
        wr(8'h00, 32'h102);
        chk(main_supply_rail, 32'h0);
        bus_wake_frame <= 1'b1;
        @(posedge aclk);
        bus_wake_frame <= 1'b0;
        @(posedge aclk);
        chk(main_supply_rail, 32'h1);
        rchk(8'h08, 32'h30);
        wr(8'h08, 32'h30);
        wr(8'h00, 32'h0);
        $display("test bus wake done");
    endtask
    task automatic t_sense;
        sw <= 1'b1;
        wr(8'h00, 32'h2C);
        wr(8'h04, 32'h10);
        wait_on(1, 1'b1, 50);
        for (k = 0; k < 1000 && high_side_output === 1'b1; k++) @(posedge aclk);
        chk(k, 100 * DIV);
        repeat (100) @(posedge aclk);
        chk(interrupt_out_n, 32'h1);
        rchk(8'h08, 32'h2);
        sw <= 1'b0;
        wait_on(0, 1'b0, 25000);
        chk(high_side_output, 32'h0);
        rchk(8'h08, 32'h1);
        wait_on(0, 1'b1, 300);
        sw <= 1'b1;
        wait_on(0, 1'b0, 25000);
        rchk(8'h08, 32'h3);
        wait_on(0, 1'b1, 300);
        wr(8'h04, 32'h10);
        sw <= 1'b0;
        wait_on(1, 1'b1, 50);
        wait_on(1, 1'b0, 300);
        bad = 1'b0;
        for (k = 0; k < 100; k++) begin
            @(posedge aclk);
            bad = bad | !interrupt_out_n;
        end
        chk(bad, 32'h0);
        wr(8'h04, 32'h0);
        wr(8'h00, 32'h0);
        $display("test periodic sense done");
    endtask

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    initial begin
        aresetn = 1'b0;
        sw = 1'b0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_awprot = 3'h0;
        s_axi_arprot = 3'h0;
        s_axi_wstrb = 4'hF;
        gpio_wake_input = 1'b0;
        bus_wake_pattern = 1'b0;
        bus_wake_frame = 1'b0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs();
        t_fail();
        t_sleep();
        t_bus();
        t_sense();
        print_verdict();
    end
endmodule // cyclic_sense_wake_detect_tb
`default_nettype wire
